//--- design/otp_programmer.sv
// Programmer for the one-time-programmable memory port, with byte FIFO.
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`default_nettype none

// ==========================================================
// Byte FIFO
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;
    assign in_ready = cnt_reg != (AW+1)'(DEPTH);
    assign out_valid = cnt_reg != '0;
    assign out_data = mem_reg[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_comb begin
        wr_next = push ? wr_reg + 1'b1 : wr_reg;
        rd_next = pop ? rd_reg + 1'b1 : rd_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end
endmodule

// ==========================================================
// Programmer top
module otp_programmer
    import otp_prog_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int FIFO_DEPTH = 16,
    parameter int PGM_MIN = PGM_MIN_CYC,
    parameter int PGM_OVER_MAX = PGM_OVER_MAX_CYC,
    parameter int OPT_PULSE = OPT_PULSE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Device programming port
    output otp_prog_pkg::prog_pins_s pins,
    output logic crystal_out_pin,
    input wire logic [7:0] data_pin_in,
    output logic [7:0] data_pin_out,
    output logic data_pin_oe_n
);
    import otp_prog_pkg::*;
    typedef enum logic [11:0] {
        ST_IDLE = 12'h001, ST_CLEAR = 12'h002, ST_CLK_HI = 12'h004,
        ST_CLK_LO = 12'h008, ST_PGM_WAIT = 12'h010, ST_PGM_SETUP = 12'h020,
        ST_PGM_PULSE = 12'h040, ST_PGM_REL = 12'h080, ST_VRFY = 12'h100,
        ST_READ = 12'h200, ST_OPT_SETUP = 12'h400, ST_OPT_PULSE = 12'h800
    } seq_state_e;
    // ==========================================================
    // Bus slave state
    logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
    logic [7:0] waddr_reg, waddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic awready_reg, awready_next, wready_reg, wready_next;
    logic bvalid_reg, bvalid_next, arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [TIMER_W-1:0] pulse_reg, pulse_next;
    logic commit, fifo_wr, start;
    // Sequencer state
    seq_state_e state_reg, state_next;
    logic [TIMER_W-1:0] timer_reg, timer_next;
    logic [CTRL_COUNT_W-1:0] count_reg, count_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    prog_pins_s pins_reg, pins_next;
    logic [7:0] dout_reg, dout_next, byte_reg, byte_next;
    logic [7:0] rbyte_reg, rbyte_next;
    logic doe_n_reg, doe_n_next, verr_reg, verr_next, prog_reg, prog_next;
    logic fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [7:0] fifo_out_data;
    logic timer_done;
    byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) byte_fifo_inst (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(fifo_wr),
        .in_ready(fifo_in_ready),
        .in_data(wdata_reg[7:0]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // A full FIFO holds the write response back, so software stalls.
    assign commit = aw_have_reg && w_have_reg && !bvalid_reg
        && (waddr_reg != REG_FIFO || fifo_in_ready);
    assign fifo_wr = commit && waddr_reg == REG_FIFO && wstrb_reg[0];
    assign start = commit && waddr_reg == REG_CTRL && wstrb_reg[0]
        && state_reg == ST_IDLE;
    assign timer_done = timer_reg == '0;

    // ==========================================================
    // Bus slave
    always_comb begin
        logic [31:0] merged;
        logic [31:0] clamped;
        merged = {{(32-TIMER_W){1'b0}}, pulse_reg};
        for (int b = 0; b < 4; b++) begin
            if (wstrb_reg[b]) begin
                merged[b*8 +: 8] = wdata_reg[b*8 +: 8];
            end
        end
        // Pulse length is kept between the least normal and the longest
        // overprogram width.
        clamped = merged;
        if (merged < 32'(PGM_MIN)) begin
            clamped = 32'(PGM_MIN);
        end else if (merged > 32'(PGM_OVER_MAX)) begin
            clamped = 32'(PGM_OVER_MAX);
        end
        aw_have_next = aw_have_reg;
        w_have_next = w_have_reg;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg && !bready;
        bresp_next = bresp_reg;
        pulse_next = pulse_reg;
        if (awvalid && awready_reg) begin
            aw_have_next = 1'b1;
            waddr_next = awaddr;
        end
        if (wvalid && wready_reg) begin
            w_have_next = 1'b1;
            wdata_next = wdata;
            wstrb_next = wstrb;
        end
        if (commit) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            case (waddr_reg)
                REG_CTRL, REG_FIFO, REG_STATUS, REG_RDATA: begin
                end
                REG_PULSE: begin
                    pulse_next = clamped[TIMER_W-1:0];
                end
                default: begin
                    bresp_next = RESP_SLVERR;
                end
            endcase
        end
        awready_next = !aw_have_next;
        wready_next = !w_have_next;
        rvalid_next = rvalid_reg && !rready;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            rdata_next = '0;
            case (araddr)
                REG_CTRL: begin
                end
                REG_STATUS: begin
                    rdata_next[STAT_BUSY_BIT] = state_reg != ST_IDLE;
                    rdata_next[STAT_VERR_BIT] = verr_reg;
                    rdata_next[STAT_EMPTY_BIT] = !fifo_out_valid;
                    rdata_next[STAT_FULL_BIT] = !fifo_in_ready;
                    rdata_next[STAT_ADDR_LSB +: ADDR_W] = addr_reg;
                end
                REG_PULSE: begin
                    rdata_next[TIMER_W-1:0] = pulse_reg;
                end
                REG_RDATA: begin
                    rdata_next[7:0] = rbyte_reg;
                end
                REG_FIFO: begin
                end
                default: begin
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end
        arready_next = !rvalid_next;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            waddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
            pulse_reg <= TIMER_W'(PGM_MIN);
        end else begin
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            pulse_reg <= pulse_next;
        end
    end

    // ==========================================================
    // Programming sequencer
    always_comb begin
        state_next = state_reg;
        timer_next = timer_done ? timer_reg : timer_reg - 1'b1;
        count_next = count_reg;
        addr_next = addr_reg;
        pins_next = pins_reg;
        dout_next = dout_reg;
        doe_n_next = doe_n_reg;
        byte_next = byte_reg;
        rbyte_next = rbyte_reg;
        verr_next = verr_reg;
        prog_next = prog_reg;
        fifo_pop = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                // Every input stays at a defined level while idle.
                pins_next = PINS_IDLE;
                doe_n_next = 1'b0;
                dout_next = 8'h00;
                if (start) begin
                    verr_next = 1'b0;
                    count_next = wdata_reg[CTRL_COUNT_LSB +: CTRL_COUNT_W];
                    prog_next = 1'b0;
                    timer_next = TIMER_W'(SETUP_CYC);
                    state_next = ST_CLEAR;
                    case (wdata_reg[CTRL_CMD_LSB +: CTRL_CMD_W])
                        CMD_CLEAR: begin
                            // No count pulse while clear is high.
                            pins_next.address_clear_pin = 1'b1;
                            addr_next = '0;
                        end
                        CMD_STEP: begin
                            if (count_next != '0) begin
                                pins_next.address_count_clock_pin = 1'b1;
                                addr_next = addr_reg + 1'b1;
                                state_next = ST_CLK_HI;
                            end
                        end
                        CMD_PROGRAM: begin
                            prog_next = 1'b1;
                            if (count_next != '0) begin
                                state_next = ST_PGM_WAIT;
                            end
                        end
                        CMD_READ: begin
                            // Read levels; the bus is released.
                            doe_n_next = 1'b1;
                            pins_next.crystal_in_pin = 1'b0;
                            pins_next.output_enable_port_pin = 1'b0;
                            timer_next = TIMER_W'(ACCESS_CYC);
                            state_next = ST_READ;
                        end
                        CMD_OPTION: begin
                            // Output enable level picks the option pair.
                            pins_next.supply_port_pin = 1'b1;
                            pins_next.output_enable_port_pin =
                                wdata_reg[CTRL_OPT_SEL_BIT];
                            state_next = ST_OPT_SETUP;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_CLEAR: begin
                if (timer_done) begin
                    pins_next.address_clear_pin = 1'b0;
                    pins_next.strobe_port_pin = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            ST_CLK_HI: begin
                if (timer_done) begin
                    pins_next.address_count_clock_pin = 1'b0;
                    timer_next = TIMER_W'(SETUP_CYC);
                    state_next = ST_CLK_LO;
                end
            end
            ST_CLK_LO: begin
                if (timer_done) begin
                    timer_next = TIMER_W'(SETUP_CYC);
                    if (prog_reg) begin
                        state_next = count_reg == '0 ? ST_CLEAR : ST_PGM_WAIT;
                    end else if (count_reg <= CTRL_COUNT_W'(1)) begin
                        count_next = '0;
                        state_next = ST_CLEAR;
                    end else begin
                        count_next = count_reg - 1'b1;
                        pins_next.address_count_clock_pin = 1'b1;
                        addr_next = addr_reg + 1'b1;
                        state_next = ST_CLK_HI;
                    end
                end
            end
            ST_PGM_WAIT: begin
                // An empty FIFO simply stalls the programming run.
                if (fifo_out_valid) begin
                    fifo_pop = 1'b1;
                    byte_next = fifo_out_data;
                    dout_next = fifo_out_data;
                    doe_n_next = 1'b0;
                    pins_next.supply_port_pin = 1'b1;
                    pins_next.crystal_in_pin = 1'b1;
                    pins_next.output_enable_port_pin = 1'b1;
                    timer_next = TIMER_W'(SETUP_CYC);
                    state_next = ST_PGM_SETUP;
                end
            end
            ST_PGM_SETUP: begin
                if (timer_done) begin
                    pins_next.crystal_in_pin = 1'b0;
                    timer_next = pulse_reg;
                    state_next = ST_PGM_PULSE;
                end
            end
            ST_PGM_PULSE: begin
                if (timer_done) begin
                    pins_next.crystal_in_pin = 1'b1;
                    doe_n_next = 1'b1;
                    timer_next = TIMER_W'(FLOAT_CYC);
                    state_next = ST_PGM_REL;
                end
            end
            ST_PGM_REL: begin
                if (timer_done) begin
                    pins_next.crystal_in_pin = 1'b0;
                    pins_next.output_enable_port_pin = 1'b0;
                    timer_next = TIMER_W'(ACCESS_CYC);
                    state_next = ST_VRFY;
                end
            end
            ST_VRFY: begin
                if (timer_done) begin
                    if (data_pin_in != byte_reg) begin
                        verr_next = 1'b1;
                    end
                    pins_next.crystal_in_pin = 1'b1;
                    pins_next.output_enable_port_pin = 1'b1;
                    count_next = count_reg - 1'b1;
                    pins_next.address_count_clock_pin = 1'b1;
                    addr_next = addr_reg + 1'b1;
                    timer_next = TIMER_W'(SETUP_CYC);
                    state_next = ST_CLK_HI;
                end
            end
            ST_READ: begin
                if (timer_done) begin
                    rbyte_next = data_pin_in;
                    pins_next.crystal_in_pin = 1'b1;
                    pins_next.output_enable_port_pin = 1'b1;
                    timer_next = TIMER_W'(FLOAT_CYC);
                    state_next = ST_CLEAR;
                end
            end
            ST_OPT_SETUP: begin
                if (timer_done) begin
                    pins_next.strobe_port_pin = 1'b0;
                    timer_next = TIMER_W'(OPT_PULSE);
                    state_next = ST_OPT_PULSE;
                end
            end
            ST_OPT_PULSE: begin
                if (timer_done) begin
                    pins_next.strobe_port_pin = 1'b1;
                    timer_next = TIMER_W'(SETUP_CYC);
                    state_next = ST_CLEAR;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            timer_reg <= '0;
            count_reg <= '0;
            addr_reg <= '0;
            pins_reg <= PINS_IDLE;
            dout_reg <= 8'h00;
            doe_n_reg <= 1'b0;
            byte_reg <= 8'h00;
            rbyte_reg <= 8'h00;
            verr_reg <= 1'b0;
            prog_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            count_reg <= count_next;
            addr_reg <= addr_next;
            pins_reg <= pins_next;
            dout_reg <= dout_next;
            doe_n_reg <= doe_n_next;
            byte_reg <= byte_next;
            rbyte_reg <= rbyte_next;
            verr_reg <= verr_next;
            prog_reg <= prog_next;
        end
    end

    // The device ignores crystal-out, so it is held at a quiet low level.
    always_ff @(posedge clk) begin
        crystal_out_pin <= 1'b0;
    end
    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign pins = pins_reg;
    assign data_pin_out = dout_reg;
    assign data_pin_oe_n = doe_n_reg;
endmodule
`default_nettype wire

//--- common/otp_prog_pkg.sv
// Constants, register map and pin bundle of the memory programmer.
`default_nettype none
package otp_prog_pkg;
    // ==========================================================
    // Register map (byte addresses on the AXI4-Lite bus)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_PULSE = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0C;
    localparam logic [7:0] REG_FIFO = 8'h10;
    // ==========================================================
    // Field positions
    localparam int CTRL_CMD_LSB = 0;
    localparam int CTRL_CMD_W = 3;
    localparam int CTRL_OPT_SEL_BIT = 4;
    localparam int CTRL_COUNT_LSB = 8;
    localparam int CTRL_COUNT_W = 16;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_VERR_BIT = 1;
    localparam int STAT_EMPTY_BIT = 2;
    localparam int STAT_FULL_BIT = 3;
    localparam int STAT_ADDR_LSB = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // Commands
    localparam logic [2:0] CMD_CLEAR = 3'h1;
    localparam logic [2:0] CMD_STEP = 3'h2;
    localparam logic [2:0] CMD_PROGRAM = 3'h3;
    localparam logic [2:0] CMD_READ = 3'h4;
    localparam logic [2:0] CMD_OPTION = 3'h5;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int SETUP_US = 2;
    localparam int ACCESS_NS = 200;
    localparam int FLOAT_NS = 100;
    localparam real PGM_MIN_MS = 0.95;
    localparam real PGM_OVER_MAX_MS = 2.85;
    localparam real OPT_PULSE_MS = 78.0;
    localparam int SETUP_CYC = (SETUP_US * 1000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // One extra cycle covers the register stage in front of data_pin_in.
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS + 1;
    localparam int FLOAT_CYC = (FLOAT_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int PGM_MIN_CYC = int'($ceil(PGM_MIN_MS * 1.0e6
        / CLK_PERIOD_NS));
    localparam int PGM_OVER_MAX_CYC = int'($floor(PGM_OVER_MAX_MS * 1.0e6
        / CLK_PERIOD_NS));
    localparam int OPT_PULSE_CYC = int'($ceil(OPT_PULSE_MS * 1.0e6
        / CLK_PERIOD_NS));
    localparam int TIMER_W = 22;
    // ==========================================================
    // Control pins toward the device
    typedef struct packed {
        logic supply_port_pin;
        logic mode_select_port_pin;
        logic crystal_in_pin;
        logic output_enable_port_pin;
        logic strobe_port_pin;
        logic address_clear_pin;
        logic address_count_clock_pin;
    } prog_pins_s;
    localparam prog_pins_s PINS_IDLE = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1,
        1'b0, 1'b0};
endpackage
`default_nettype wire

//--- verif/otp_programmer_props.sv
// Checker of the programming port pin sequences.
`default_nettype none
// ========
// Checker
module otp_programmer_props
    import otp_prog_pkg::*;
#(
    parameter int PGM_MIN = 20,
    parameter int PGM_OVER_MAX = 60
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Port pins
    input wire otp_prog_pkg::prog_pins_s pins,
    input wire logic crystal_out_pin,
    input wire logic data_pin_oe_n
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    // Counts only cycles of a program pulse, not of a read access.
    always_comb begin
        cnt_next = 32'h0;
        if (!pins.crystal_in_pin && pins.output_enable_port_pin)
            cnt_next = cnt_reg + 32'h1;
    end
    always_ff @(posedge clk) begin
        cnt_reg <= rst_n ? cnt_next : 32'h0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_pulse_width_ok: assert property (
        $rose(pins.crystal_in_pin) && $past(pins.output_enable_port_pin)
        |-> cnt_reg >= PGM_MIN && cnt_reg <= PGM_OVER_MAX + 2)
        else $error("program pulse width out of range");
    a_option_levels: assert property (
        !pins.strobe_port_pin |-> pins.supply_port_pin
        && pins.crystal_in_pin && pins.mode_select_port_pin)
        else $error("option strobe with wrong levels");
    a_read_released: assert property (
        !pins.crystal_in_pin && !pins.output_enable_port_pin
        |-> data_pin_oe_n && pins.strobe_port_pin)
        else $error("data bus driven during device output");
    a_program_drive: assert property (
        !pins.crystal_in_pin && pins.output_enable_port_pin
        |-> pins.supply_port_pin && !data_pin_oe_n)
        else $error("program pulse without supply or data");
    a_defined_levels: assert property (
        pins.mode_select_port_pin && !crystal_out_pin)
        else $error("mode or crystal out level lost");
    a_clear_alone: assert property (
        $rose(pins.address_clear_pin) |-> (pins.address_clear_pin
        && !pins.address_count_clock_pin) [*8])
        else $error("clear too short or met by count clock");
endmodule
bind otp_programmer otp_programmer_props #(.PGM_MIN(PGM_MIN),
    .PGM_OVER_MAX(PGM_OVER_MAX)) otp_programmer_props_inst (.clk(clk),
    .rst_n(rst_n), .pins(pins), .crystal_out_pin(crystal_out_pin),
    .data_pin_oe_n(data_pin_oe_n));
`default_nettype wire

//--- verif/otp_device_model.sv
// Behavioural model of the memory device in programming mode.
`default_nettype none
// ========
// Device
module otp_device_model
    import otp_prog_pkg::*;
(
    // Clock and port pins; crystal-out is not an input at all
    input wire logic clk,
    input wire otp_prog_pkg::prog_pins_s pins,
    input wire logic [7:0] data_pin_out,
    output logic [7:0] data_pin_in
);
    logic [7:0] mem [256];
    logic [15:0] addr = 16'h0;
    logic cnt_q = 1'b0;
    logic protect = 1'b0;
    logic rc_osc = 1'b0;
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        data_pin_in = 8'h00;
    end
    // Programming can only clear bits, as in a real fuse array.
    always @(posedge clk) begin
        cnt_q <= pins.address_count_clock_pin;
        if (pins.address_clear_pin) addr <= 16'h0;
        else if (pins.address_count_clock_pin && !cnt_q)
            addr <= addr + 16'h1;
        if (pins.supply_port_pin && !pins.crystal_in_pin
            && pins.output_enable_port_pin)
            mem[addr[7:0]] <= mem[addr[7:0]] & data_pin_out;
        if (pins.supply_port_pin && !pins.strobe_port_pin) begin
            if (pins.output_enable_port_pin) protect <= 1'b1;
            else rc_osc <= 1'b1;
        end
        // A released bus toggles, so stale data never matches.
        if (!pins.crystal_in_pin && !pins.output_enable_port_pin)
            data_pin_in <= mem[addr[7:0]];
        else data_pin_in <= ~data_pin_in;
    end
endmodule
`default_nettype wire

//--- verif/otp_programmer_tb.sv
// Self-checking testbench of the memory programmer.
`default_nettype none
// ========
// Bench
module otp_programmer_tb;
    import otp_prog_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready;
    logic rvalid, crystal_out_pin, data_pin_oe_n;
    logic [7:0] awaddr = 0, araddr = 0, data_pin_in, data_pin_out;
    logic [31:0] wdata = 0, rdata, last;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp;
    prog_pins_s pins;
    int miscompares = 0, checked = 0, seed = 32'h3e5e;
    logic [67:0] rq[$];
    logic [1:0] bq[$];
    logic [7:0] b[17];
    always #10 clk = ~clk;
    otp_programmer #(.PGM_MIN(20), .PGM_OVER_MAX(60), .OPT_PULSE(40))
        otp_programmer_inst (.clk, .rst_n, .awvalid, .awready, .awaddr,
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
        .pins, .crystal_out_pin, .data_pin_in, .data_pin_out,
        .data_pin_oe_n);
    otp_device_model otp_device_model_inst (.clk, .pins, .data_pin_out,
        .data_pin_in);
    task automatic chk(string n, logic [33:0] s, logic [33:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    always @(posedge clk) begin
        logic [67:0] n;
        if (bvalid && bready) chk("bresp", 34'(bresp), 34'(bq.pop_front()));
        if (rvalid && rready) begin
            n = rq.pop_front();
            chk("rdata", {rresp, rdata} & n[67:34], n[33:0]);
        end
    end
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
        @(posedge clk);
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (awvalid || wvalid || !bvalid);
        bready <= 0;
    endtask
    task automatic rd(logic [7:0] a, logic [33:0] e, logic [33:0] m);
        @(posedge clk);
        rq.push_back({m, e});
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 0;
        end while (arvalid || !rvalid);
        last = rdata;
        rready <= 0;
    endtask
    task automatic cmd(logic [31:0] c);
        wr(REG_CTRL, c, RESP_OKAY);
        do rd(REG_STATUS, 0, {2'h3, 32'h0}); while (last[0] !== 1'b0);
    endtask
    task automatic close_out;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #(20 * 60000);
        miscompares++;
        close_out;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1;
        rd(REG_PULSE, 34'd20, '1);
        wr(REG_PULSE, 32'd5, RESP_OKAY);
        rd(REG_PULSE, 34'd20, '1);
        wr(REG_PULSE, 32'h64, RESP_OKAY);
        rd(REG_PULSE, 34'h3C, '1);
        wr(8'h14, 32'h1, RESP_SLVERR);
        rd(8'h14, {RESP_SLVERR, 32'h0}, '1);
        cmd(CMD_CLEAR);
        foreach (b[i]) b[i] = 8'($random(seed));
        b[0][7] = 1'b0;
        for (int i = 0; i < 16; i++) wr(REG_FIFO, b[i], RESP_OKAY);
        rd(REG_STATUS, 34'h8, '1);
        wr(REG_CTRL, 32'h1100 | CMD_PROGRAM, RESP_OKAY);
        wr(REG_FIFO, b[16], RESP_OKAY);
        cmd(32'h0);
        rd(REG_STATUS, 34'h110004, '1);
        foreach (b[i])
            chk("mem", 34'(otp_device_model_inst.mem[i]), 34'(b[i]));
        cmd(CMD_CLEAR);
        cmd(CMD_READ);
        rd(REG_RDATA, 34'(b[0]), '1);
        cmd(32'h200 | CMD_STEP);
        cmd(CMD_READ);
        rd(REG_RDATA, 34'(b[2]), '1);
        cmd(CMD_CLEAR);
        wr(REG_FIFO, 32'hFF, RESP_OKAY);
        cmd(32'h100 | CMD_PROGRAM);
        rd(REG_STATUS, 34'h10006, '1);
        cmd(CMD_OPTION);
        cmd(32'h10 | CMD_OPTION);
        rd(REG_STATUS, 34'h10004, '1);
        chk("options", 34'({otp_device_model_inst.protect,
            otp_device_model_inst.rc_osc}), 34'h3);
        close_out;
    end
endmodule
`default_nettype wire
